// file: core/pst_pkg.sv
// Package of constants and types for the sync trigger and slot control block
package pst_pkg;

    // ************************************************************
    // Timing constants
    // ************************************************************
    localparam int CLK_PERIOD_PS        = 4000;   // 250 MHz system clock
    localparam int BLANK_MIN_NS         = 121000; // Shortest blanking window
    localparam int BLANK_MAX_NS         = 135000; // Longest blanking window
    // Blanking aims at the middle of the window, rounded up to whole cycles
    localparam int BLANK_CYC            =
        ((BLANK_MIN_NS + BLANK_MAX_NS) / 2 * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int SYNC_PERIOD_MIN_NS   = 250000; // Far side spacing, least
    localparam int SYNC_PERIOD_TYP_NS   = 500000; // Far side spacing, typical
    localparam int PULSE_MIN_PS         = 17670000; // Far side pulse, least
    localparam int PULSE_MAX_NS         = 62000;    // Far side pulse, most
    localparam int ASYNC_PERIOD_NS      = 500000;   // Free-running period
    localparam int ASYNC_PERIOD_CYC     =
        ASYNC_PERIOD_NS * 1000 / CLK_PERIOD_PS;

    // ************************************************************
    // Configuration field layout and reset values
    // ************************************************************
    localparam int    INIT_BLOCKS_SHORT = 22;  // Extended bit clear
    localparam int    INIT_BLOCKS_LONG  = 32;  // Extended bit set
    localparam logic [1:0] SLOT_RST     = 2'h0;
    localparam int    DATA_W            = 16;
    localparam int    HALF_W            = 8;
    localparam int    ANGLE_W           = 14;

    // ************************************************************
    // Modes and commands
    // ************************************************************
    typedef enum logic [1:0] {
        PST_BUS_POINT    = 2'b00,  // Point to point
        PST_BUS_UNIVERSAL = 2'b01, // Universal bus
        PST_BUS_PARALLEL = 2'b10,  // Parallel bus
        PST_BUS_DAISY    = 2'b11   // Daisy chain, refused
    } pst_bus_e;

    typedef enum logic [1:0] {
        PST_CMD_NONE  = 2'b00,
        PST_CMD_WRITE = 2'b01,  // Write one setting byte
        PST_CMD_READ  = 2'b10   // Read a measurement value
    } pst_cmd_e;

    localparam logic [1:0] RD_FIELD = 2'h0;  // Field magnitude
    localparam logic [1:0] RD_AGC   = 2'h1;  // Gain control value
    localparam logic [1:0] RD_ANGLE = 2'h2;  // Angle

    // Non-volatile settings image
    typedef struct packed {
        logic                 async_mode;    // Free-running transmission
        logic                 legacy_10bit;  // Old protocol version
        logic                 wide_16bit;    // 16-bit word, else 12-bit
        logic                 extended_init; // 32 init blocks, else 22
        logic [1:0]           bus_mode;      // pst_bus_e code
        logic [1:0]           bus_slot_select;
        logic [ANGLE_W-1:0]   start_pos;     // Zero angle
        logic [ANGLE_W-1:0]   stop_pos;      // Maximum angle
    } pst_cfg_s;

    // Programming channel command after byte decoding
    typedef struct packed {
        logic       valid;
        logic [1:0] cmd;
        logic [3:0] addr;
        logic [7:0] data;
    } pst_prog_s;

    // Measurement values from the datapath
    typedef struct packed {
        logic [15:0]        field_magnitude;
        logic [7:0]         agc;
        logic [ANGLE_W-1:0] angle;
    } pst_meas_s;

    // Programming addresses of settings bytes
    localparam logic [3:0] PA_MODE     = 4'h0;
    localparam logic [3:0] PA_START_LO = 4'h1;
    localparam logic [3:0] PA_START_HI = 4'h2;
    localparam logic [3:0] PA_STOP_LO  = 4'h3;
    localparam logic [3:0] PA_STOP_HI  = 4'h4;

endpackage

// file: core/pst_core.sv
// Sync trigger detection, blanking, slot selection and programming control
`timescale 1ns/1ps
module pst_core #(
    parameter int BLANK_CYCLES = pst_pkg::BLANK_CYC,
    parameter int ASYNC_CYCLES = pst_pkg::ASYNC_PERIOD_CYC
) (
    // Clock and reset
    input  wire logic                sys_clk_i,
    input  wire logic                sys_rst_i,
    // Analog trigger comparator
    input  wire logic                trig_cmp_i,
    // Programming channel and measurements
    input  wire pst_pkg::pst_prog_s  prog_i,
    input  wire pst_pkg::pst_meas_s  meas_i,
    input  wire logic                prog_mode_i,
    // Data word to send
    input  wire logic [15:0]         word_i,
    // Outputs
    output logic                     trig_o,
    output logic                     frame_start_o,
    output logic [7:0]               frame_data_o,
    output logic                     frame_half_o,
    output logic [1:0]               slot_o,
    output logic [5:0]               init_blocks_o,
    output logic                     otp_we_o,
    output logic [3:0]               otp_addr_o,
    output logic [7:0]               otp_data_o,
    output logic                     rd_valid_o,
    output logic [15:0]              rd_data_o,
    output pst_pkg::pst_cfg_s        cfg_o,
    output logic                     bus_err_o
);

    // ************************************************************
    // Trigger synchroniser and edge detect
    // ************************************************************
    logic        sync1_r;  // First stage, read only by second stage
    logic        sync2_r;
    logic        sync3_r;  // Delayed copy for the edge detector
    logic [16:0] blank_cnt_r;  // Blanking countdown
    logic        rise;
    logic        blanking;

    // Two flops guard against a metastable comparator edge
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
        end else begin
            sync1_r <= trig_cmp_i;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    assign rise     = sync2_r & ~sync3_r;
    assign blanking = (blank_cnt_r != 17'h0);

    // Count down from the accepted edge; EMC bursts hit nothing meanwhile
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            blank_cnt_r <= 17'h0;
        end else if (rise && !blanking) begin
            blank_cnt_r <= 17'(BLANK_CYCLES);
        end else if (blanking) begin
            blank_cnt_r <= blank_cnt_r - 17'h1;
        end
    end

    // Accepted trigger pulse
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            trig_o <= 1'b0;
        end else begin
            trig_o <= rise & ~blanking;
        end
    end

    // ************************************************************
    // Settings image written by programming
    // ************************************************************
    pst_pkg::pst_cfg_s cfg_r;

    // Only in programming mode; one-time memory sees each write
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cfg_r <= '0;
            cfg_r.bus_slot_select <= pst_pkg::SLOT_RST;
        end else if (prog_mode_i && prog_i.valid
                     && prog_i.cmd == pst_pkg::PST_CMD_WRITE) begin
            unique case (prog_i.addr)
                pst_pkg::PA_MODE: begin
                    cfg_r.async_mode      <= prog_i.data[0];
                    cfg_r.legacy_10bit    <= prog_i.data[1];
                    cfg_r.wide_16bit      <= prog_i.data[2];
                    cfg_r.extended_init   <= prog_i.data[3];
                    cfg_r.bus_mode        <= prog_i.data[5:4];
                    cfg_r.bus_slot_select <= prog_i.data[7:6];
                end
                pst_pkg::PA_START_LO: begin
                    cfg_r.start_pos[7:0] <= prog_i.data;
                end
                pst_pkg::PA_START_HI: begin
                    cfg_r.start_pos[13:8] <= prog_i.data[5:0];
                end
                pst_pkg::PA_STOP_LO: begin
                    cfg_r.stop_pos[7:0] <= prog_i.data;
                end
                pst_pkg::PA_STOP_HI: begin
                    cfg_r.stop_pos[13:8] <= prog_i.data[5:0];
                end
                default: begin
                    cfg_r <= cfg_r;  // Other bytes only reach the memory
                end
            endcase
        end
    end

    assign cfg_o = cfg_r;

    // Forward each write made in programming mode to the one-time memory port
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            otp_we_o   <= 1'b0;
            otp_addr_o <= 4'h0;
            otp_data_o <= 8'h00;
        end else begin
            otp_we_o   <= prog_mode_i && prog_i.valid
                          && prog_i.cmd == pst_pkg::PST_CMD_WRITE;
            otp_addr_o <= prog_i.addr;
            otp_data_o <= prog_i.data;
        end
    end

    // Measurement read-back
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rd_valid_o <= 1'b0;
            rd_data_o  <= 16'h0;
        end else begin
            rd_valid_o <= prog_mode_i && prog_i.valid
                          && prog_i.cmd == pst_pkg::PST_CMD_READ;
            unique case (prog_i.addr[1:0])
                pst_pkg::RD_FIELD: rd_data_o <= meas_i.field_magnitude;
                pst_pkg::RD_AGC:   rd_data_o <= {8'h0, meas_i.agc};
                pst_pkg::RD_ANGLE: rd_data_o <= {2'h0, meas_i.angle};
                default:           rd_data_o <= 16'h0;
            endcase
        end
    end

    // ************************************************************
    // Bus mode, slot and init length
    // ************************************************************
    // Daisy chain addressing is not built; flag it and send no frames
    assign bus_err_o = (cfg_r.bus_mode == pst_pkg::PST_BUS_DAISY);
    // Legacy asynchronous sends in a single slot only
    assign slot_o = (cfg_r.async_mode && cfg_r.legacy_10bit) ?
                    2'h0 : cfg_r.bus_slot_select;
    assign init_blocks_o = cfg_r.extended_init ?
        6'(pst_pkg::INIT_BLOCKS_LONG) :
        6'(pst_pkg::INIT_BLOCKS_SHORT);

    // ************************************************************
    // Frame scheduling
    // ************************************************************
    logic [19:0] period_cnt_r;  // Free-running period timer
    logic        period_tick;
    logic        half_r;        // Which half of a split word is next
    logic        split;

    assign period_tick = (period_cnt_r == 20'h0);
    assign split = cfg_r.async_mode && cfg_r.legacy_10bit;

    // Asynchronous period timer
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || !cfg_r.async_mode) begin
            period_cnt_r <= 20'(ASYNC_CYCLES - 1);
        end else if (period_tick) begin
            period_cnt_r <= 20'(ASYNC_CYCLES - 1);
        end else begin
            period_cnt_r <= period_cnt_r - 20'h1;
        end
    end

    // Frame launch: trigger in sync mode, timer in async mode
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            frame_start_o <= 1'b0;
            frame_data_o  <= 8'h00;
            frame_half_o  <= 1'b0;
            half_r        <= 1'b0;
        end else begin
            frame_start_o <= 1'b0;
            if ((cfg_r.async_mode ? period_tick
                 : (rise && !blanking)) && !bus_err_o) begin
                frame_start_o <= 1'b1;
                frame_half_o  <= split & half_r;
                if (split) begin
                    // Low half first, high half next period
                    frame_data_o <= half_r ? word_i[15:8]
                                           : word_i[7:0];
                    half_r       <= ~half_r;
                end else begin
                    frame_data_o <= word_i[7:0];
                    half_r       <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    logic [16:0] blank_seen_r;  // Cycles since the last accepted trigger

    // Starts saturated so the first trigger after reset is free; follows
    // the parameter so a shortened blanking is checked just as tightly
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            blank_seen_r <= 17'(BLANK_CYCLES);
        end else if (trig_o) begin
            blank_seen_r <= 17'h0;
        end else if (blank_seen_r < 17'(BLANK_CYCLES)) begin
            blank_seen_r <= blank_seen_r + 17'h1;
        end
    end

    AST_BLANK: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        trig_o |-> blank_seen_r >= 17'(BLANK_CYCLES))
        else $error("trigger inside blanking window");
    AST_REFUSE: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        rise && blanking |=> !trig_o)
        else $error("edge accepted while blanking");
    AST_SYNC: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        trig_o |-> $past(sync2_r) && !$past(sync3_r))
        else $error("trigger without synchronised edge");
    AST_SLOT: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        split |-> slot_o == 2'h0)
        else $error("legacy async uses extra slot");
    AST_SPLIT: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        frame_start_o && $past(split)
        |-> frame_data_o == (frame_half_o ? $past(word_i[15:8])
                                          : $past(word_i[7:0])))
        else $error("split word half out of place");
    AST_DAISY: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        bus_err_o |=> !frame_start_o)
        else $error("frame sent in daisy chain mode");
    AST_INIT: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        init_blocks_o == (cfg_r.extended_init ? 6'h20 : 6'h16))
        else $error("wrong init block count");
    AST_OTP: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        prog_mode_i && prog_i.valid && prog_i.cmd == pst_pkg::PST_CMD_WRITE
        |=> otp_we_o && otp_addr_o == $past(prog_i.addr)
            && otp_data_o == $past(prog_i.data))
        else $error("programming write lost");
    AST_READ: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        prog_mode_i && prog_i.valid && prog_i.cmd == pst_pkg::PST_CMD_READ
        && prog_i.addr[1:0] == pst_pkg::RD_ANGLE
        |=> rd_valid_o && rd_data_o == {2'h0, $past(meas_i.angle)})
        else $error("angle read wrong");
    AST_START: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        prog_mode_i && prog_i.valid && prog_i.cmd == pst_pkg::PST_CMD_WRITE
        && prog_i.addr == pst_pkg::PA_START_LO
        |=> cfg_r.start_pos[7:0] == $past(prog_i.data))
        else $error("start position not stored");

    COV_TRIG:  cover property (@(posedge sys_clk_i) trig_o);
    COV_ASYNC: cover property (@(posedge sys_clk_i)
        frame_start_o && cfg_r.async_mode);
    COV_HALF:  cover property (@(posedge sys_clk_i)
        frame_start_o && frame_half_o);
    COV_READ:  cover property (@(posedge sys_clk_i) rd_valid_o);

endmodule

// file: bench/pst_ecu_model.sv
// Control unit model that raises sync pulses on the supply line comparator
`timescale 1ns/1ps
module pst_ecu_model #(
    parameter int PULSE_CYC = 10   // Pulse width, shortened with the blanking
) (
    // Clock and requests from the bench
    input  wire logic sys_clk_i,
    input  wire logic go_i,
    input  wire logic glitch_i,
    // Comparator level seen by the device
    output logic      trig_cmp_o
);
    // ************************************************************
    // Pulse shaper
    // ************************************************************
    int   ph_r  = 0;     // Phase within one pulse, 0 when idle
    logic glt_r = 1'b0;  // Disturbance after the pulse requested
    logic go_q  = 1'b0;  // Request as taken at the rising edge
    logic glt_q = 1'b0;  // Disturbance request, same edge
    // Requests change on the falling edge; taking them on the rising one
    // keeps the shaper from racing the bench
    always @(posedge sys_clk_i) begin
        go_q  <= go_i;
        glt_q <= glitch_i;
    end
    // Pulse width fixed, spacing left to the bench
    // Disturbance re-rises the line soon after the pulse, inside blanking
    always @(negedge sys_clk_i) begin
        if (ph_r == 0 && go_q) begin
            ph_r  = 1;
            glt_r = glt_q;
        end else if (ph_r != 0) begin
            ph_r = (ph_r >= PULSE_CYC + 6) ? 0 : ph_r + 1;
        end
        trig_cmp_o = (ph_r != 0 && ph_r <= PULSE_CYC) ||
                     (glt_r && (ph_r == PULSE_CYC + 3 ||
                                ph_r == PULSE_CYC + 4));
    end
endmodule

// file: bench/psi5_sync_trigger_and_slot_control_bench.sv
// Self-checking bench of the sync trigger and slot control core
`timescale 1ns/1ps
module psi5_sync_trigger_and_slot_control_bench;
    // ************************************************************
    // Signals and bookkeeping
    // ************************************************************
    localparam int BLK = 20;    // Shortened blanking
    localparam int ASY = 50;    // Shortened free-running period
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic trig_cmp_i, go, glt, prog_mode_i = 1'b0;
    logic [15:0] word_i = 16'h0;
    pst_pkg::pst_prog_s prog_i = '0;
    pst_pkg::pst_meas_s meas_i = '0;
    logic trig_o, frame_start_o, frame_half_o, otp_we_o, rd_valid_o;
    logic bus_err_o, last_half;
    logic [7:0] frame_data_o, otp_data_o;
    logic [1:0] slot_o, slot;
    logic [5:0] init_blocks_o;
    logic [3:0] otp_addr_o;
    logic [15:0] rd_data_o;
    pst_pkg::pst_cfg_s cfg_o;
    logic [11:0] wr_q[$];       // Expected write address and data
    logic [15:0] rd_q[$];       // Expected read answers
    logic [13:0] sp, ep;
    int fail_count = 0, num_checks = 0, seed = 38867;
    int cyc = 0, last_fr = 0, nfr = 0, ntrig = 0, md = 0;
    // Clock, one half period each way
    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) cyc <= cyc + 1;
    // ************************************************************
    // Instances
    // ************************************************************
    pst_ecu_model #(.PULSE_CYC(10)) ecu_u (.sys_clk_i(sys_clk_i),
        .go_i(go), .glitch_i(glt), .trig_cmp_o(trig_cmp_i));
    pst_core #(.BLANK_CYCLES(BLK), .ASYNC_CYCLES(ASY)) dut_u (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .trig_cmp_i(trig_cmp_i), .prog_i(prog_i), .meas_i(meas_i),
        .prog_mode_i(prog_mode_i), .word_i(word_i), .trig_o(trig_o),
        .frame_start_o(frame_start_o), .frame_data_o(frame_data_o),
        .frame_half_o(frame_half_o), .slot_o(slot_o),
        .init_blocks_o(init_blocks_o), .otp_we_o(otp_we_o),
        .otp_addr_o(otp_addr_o), .otp_data_o(otp_data_o),
        .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .cfg_o(cfg_o),
        .bus_err_o(bus_err_o));
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // One programming request; the next call keeps valid up back to back.
    // The note is queued at the taking edge, so the watcher finds one only
    task automatic put(input logic [1:0] c, input logic [3:0] a,
                       input logic [7:0] d);
        logic [15:0] v;
        @(negedge sys_clk_i);
        prog_i = '{1'b1, c, a, d};
        v = (a[1:0] == 2'h0) ? meas_i.field_magnitude :
            (a[1:0] == 2'h1) ? {8'h0, meas_i.agc} :
            (a[1:0] == 2'h2) ? {2'h0, meas_i.angle} : 16'h0;
        @(posedge sys_clk_i);
        if (prog_mode_i && c == pst_pkg::PST_CMD_WRITE) begin
            wr_q.push_back({a, d});
        end
        if (prog_mode_i && c == pst_pkg::PST_CMD_READ) begin
            rd_q.push_back(v);
        end
    endtask
    task automatic done;
        @(negedge sys_clk_i);
        prog_i = '0;
        repeat (3) @(negedge sys_clk_i);
    endtask
    task automatic pulse(input logic g);
        @(negedge sys_clk_i);
        go  = 1'b1;
        glt = g;
        @(negedge sys_clk_i);
        go  = 1'b0;
        repeat (BLK + 20) @(negedge sys_clk_i);
    endtask
    // ************************************************************
    // Output watcher: pops the oldest note whenever a result shows
    // ************************************************************
    always @(negedge sys_clk_i) begin
        if (!sys_rst_i && otp_we_o) begin
            check(wr_q.size(), 1);
            if (wr_q.size() > 0) begin
                check({otp_addr_o, otp_data_o}, wr_q.pop_front());
            end
        end
        if (!sys_rst_i && rd_valid_o) begin
            check(rd_q.size(), 1);
            if (rd_q.size() > 0) begin
                check(rd_data_o, rd_q.pop_front());
            end
        end
        if (trig_o) ntrig++;
        if (md == 0) check(frame_start_o, trig_o);
        if (md == 1) check(frame_start_o, 1'b0);
        if (md == 2 && frame_start_o) begin
            check(frame_data_o, frame_half_o ? word_i[15:8]
                                             : word_i[7:0]);
            check(slot_o, 2'h0);
            if (nfr == 0) check(frame_half_o, 1'b0);
            if (nfr > 0) check(frame_half_o, !last_half);
            if (nfr > 0) check(cyc - last_fr, ASY);
            last_half = frame_half_o;
            last_fr = cyc;
            nfr++;
        end
    end
    // Watchdog over the whole expected run
    initial begin
        #80000;
        fail_count++;
        report_and_stop();
    end
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        go = 1'b0;
        glt = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        check({otp_we_o, rd_valid_o, trig_o, frame_start_o}, 4'h0);
        check(init_blocks_o, 6'd22);
        meas_i = 38'({$random(seed), $random(seed)});
        word_i = 16'($random(seed));
        // Slot kept off zero so the legacy fall back to slot 0 shows
        slot = 2'($random(seed)) | 2'h1;
        sp = 14'($random(seed));
        ep = 14'($random(seed));
        prog_mode_i = 1'b1;
        // Sync mode, universal bus, extended init, back-to-back writes
        put(pst_pkg::PST_CMD_WRITE, pst_pkg::PA_MODE, {slot, 2'b01, 4'h8});
        put(pst_pkg::PST_CMD_WRITE, pst_pkg::PA_START_LO, sp[7:0]);
        put(pst_pkg::PST_CMD_WRITE, pst_pkg::PA_START_HI, {2'h0, sp[13:8]});
        put(pst_pkg::PST_CMD_WRITE, pst_pkg::PA_STOP_LO, ep[7:0]);
        put(pst_pkg::PST_CMD_WRITE, pst_pkg::PA_STOP_HI, {2'h0, ep[13:8]});
        for (int i = 0; i < 4; i++) put(pst_pkg::PST_CMD_READ, i[3:0], 8'h0);
        done();
        check(slot_o, slot);
        check(init_blocks_o, 6'd32);
        check({cfg_o.start_pos, cfg_o.stop_pos}, {sp, ep});
        check(bus_err_o, 1'b0);
        // Refused while programming is not allowed
        prog_mode_i = 1'b0;
        put(pst_pkg::PST_CMD_WRITE, pst_pkg::PA_MODE, 8'hff);
        done();
        check(cfg_o.bus_slot_select, slot);
        // Trigger with a disturbance inside blanking, then a clean one
        pulse(1'b1);
        check(ntrig, 1);
        pulse(1'b0);
        check(ntrig, 2);
        // Daisy chain refused, short init, no frames on a trigger
        prog_mode_i = 1'b1;
        put(pst_pkg::PST_CMD_WRITE, pst_pkg::PA_MODE, {slot, 2'b11, 4'h0});
        done();
        md = 1;
        check(bus_err_o, 1'b1);
        check(init_blocks_o, 6'd22);
        pulse(1'b0);
        // Legacy asynchronous, 16-bit word, parallel bus
        put(pst_pkg::PST_CMD_WRITE, pst_pkg::PA_MODE, {slot, 2'b10, 4'h7});
        md = 2;
        done();
        check(bus_err_o, 1'b0);
        repeat (5 * ASY) @(negedge sys_clk_i);
        check(nfr >= 4, 1'b1);
        check(wr_q.size() + rd_q.size(), 0);
        report_and_stop();
    end
endmodule
